// [tb/serial_remote.sv]
// remote transceiver model on the serial lines
`timescale 1ns/1ps
module serial_remote #(
  parameter int BIT = 16
) (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  logic [7:0] got;
  logic [7:0] sh;
  int         n_got;

  initial
  begin
    rxd = 1'b1;
    n_got = 0;
    got = 8'h00;
  end

  // start, eight data lsb first, stop
  always
  begin
    @(posedge clk);
    if (txd === 1'b0)
    begin
      repeat (BIT / 2) @(posedge clk);
      for (int b = 0; b < 8; b++)
      begin
        repeat (BIT) @(posedge clk);
        sh[b] = txd;
      end
      repeat (BIT) @(posedge clk);
      got = sh;
      n_got++;
    end
  end

  // one whole frame, line idles high
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask
endmodule

// [tb/serial_top_asserts.sv]
// port checker of the serial block, bound to its top module
`timescale 1ns/1ps
module serial_top_asserts (
  input wire logic                 CLK,
  input wire logic                 RSTN,
  input wire logic                 CE,
  input wire serial_pkg::apb_req_t APB_REQ,
  input wire logic [31:0]          PRDATA,
  input wire logic                 PREADY,
  input wire logic                 PSLVERR,
  input wire logic                 RXD,
  input wire logic                 TXD,
  input wire logic                 IRQ
);
  import serial_pkg::*;
  logic       txd_q;
  logic [7:0] hold_q;
  wire        acc = APB_REQ.psel && APB_REQ.penable && PREADY;
  wire  [9:0] idx = APB_REQ.paddr[11:2];

  // cycles the serial output has stood still
  always_ff @(posedge CLK or negedge RSTN)
    if (!RSTN)
    begin
      txd_q  <= 1'b1;
      hold_q <= 8'hFF;
    end
    else
    begin
      txd_q <= TXD;
      if (TXD != txd_q)
        hold_q <= 8'h00;
      else if (hold_q != 8'hFF)
        hold_q <= hold_q + 8'h01;
    end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_setup;
    APB_REQ.psel && !APB_REQ.penable;
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence

  property p_wait;   s_setup |=> s_answer; endproperty
  property p_pulse;  PREADY |=> !PREADY; endproperty
  property p_err;    PSLVERR |-> PREADY && PRDATA == 32'h0000_0000;
  endproperty
  property p_unmap;  acc && idx == 10'h056 |-> PSLVERR; endproperty
  property p_map;    acc && idx == IDX_DATA |-> !PSLVERR; endproperty
  property p_upper;  acc && !APB_REQ.pwrite |-> PRDATA[31:8] == 24'h00_0000;
  endproperty
  property p_stat0;  acc && !APB_REQ.pwrite && idx == IDX_STATUS
                     |-> !PRDATA[0]; endproperty
  property p_bit;    TXD != txd_q |-> hold_q >= 8'h0F; endproperty
  property p_idle;   $rose(RSTN) |-> TXD; endproperty

  a_wait: assert property (p_wait)
    else $error("answer not after one wait cycle");
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  a_err: assert property (p_err)
    else $error("error without ready or with data");
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  a_map: assert property (p_map)
    else $error("data access refused");
  a_upper: assert property (p_upper)
    else $error("upper read bits not zero");
  a_stat0: assert property (p_stat0)
    else $error("unused status bit set");
  a_bit: assert property (p_bit)
    else $error("serial bit shorter than sixteen cycles");
  a_idle: assert property (p_idle)
    else $error("serial output low after reset");
endmodule

bind serial_top serial_top_asserts i_chk (.CLK(CLK), .RSTN(RSTN), .CE(CE),
  .APB_REQ(APB_REQ), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .RXD(RXD), .TXD(TXD), .IRQ(IRQ));

// [tb/tb_top.sv]
// self-checking bench of the serial block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import serial_pkg::*;
  logic        clk;
  logic        rstn;
  apb_req_t    req;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  logic [31:0] seed;
  int          n_fail;
  int          check_count;
  int          n0;
  int          k;
  logic [9:0]  regs [5] = '{IDX_BAUD, IDX_CTRL1, IDX_RX_EXT, IDX_TX_EXT,
                            IDX_CTRL2};
  logic [7:0]  rate [4] = '{8'h68, 8'h02, 8'h88, 8'h00};

  serial_top i_dut (.CLK(clk), .RSTN(rstn), .CE(1'b1), .APB_REQ(req),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd),
    .TXD(txd), .IRQ(irq));
  serial_remote #(.BIT(16)) i_rem (.clk(clk), .txd(txd), .rxd(rxd));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic int period(input logic [7:0] b, input logic [7:0] x);
    int p;
    case (b[7:6])
      2'b00:   p = 1;
      2'b01:   p = 3;
      2'b10:   p = 4;
      default: p = 13;
    endcase
    return 16 * p * ((x != 0) ? int'(x) : (1 << b[5:3]));
  endfunction

  function automatic logic [7:0] exp_rd(input logic [9:0] i,
                                        input logic [7:0] v);
    return (i == IDX_CTRL1) ? (v & C1_WMASK) : v;
  endfunction

  task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h00_0000, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    rd = prdata;
    er = pslverr;
    if (n == 20)
      n_fail++;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_rem(input int n);
    k = 0;
    while (i_rem.n_got < n && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 3000)
      n_fail++;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    test_done;
  end

  initial
  begin
    req = '0;
    rstn = 1'b0;
    seed = 32'h0000_7f23;
    n_fail = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(0, IDX_STATUS, 8'h00);
    `CHK(rd[7:0], RST_STATUS)
    foreach (regs[i])
    begin
      apb(0, regs[i], 8'h00);
      `CHK(rd, 32'h0000_0000)
    end
    apb(1, 10'h056, 8'hFF);
    `CHK(er, 1'b1)
    repeat (4)
      for (int i = 0; i < 4; i++)
      begin
        seed = xs(seed);
        apb(1, regs[i], seed[7:0]);
        apb(0, regs[i], 8'h00);
        `CHK(rd[7:0], exp_rd(regs[i], seed[7:0]))
      end
    for (int i = 0; i < 4; i++)
      apb(1, regs[i], 8'h00);
    apb(1, IDX_CTRL2, 8'h0C);
    repeat (3)
    begin
      seed = xs(seed);
      n0 = i_rem.n_got;
      apb(0, IDX_STATUS, 8'h00);
      apb(1, IDX_DATA, seed[7:0]);
      wait_rem(n0 + 1);
      `CHK(i_rem.got, seed[7:0])
    end
    n0 = i_rem.n_got;
    apb(1, IDX_DATA, 8'hA5);
    repeat (400) @(posedge clk);
    `CHK(i_rem.n_got, n0)
    apb(1, IDX_CTRL2, 8'h0D);
    apb(1, IDX_CTRL2, 8'h0C);
    wait_rem(n0 + 1);
    repeat (400) @(posedge clk);
    `CHK(i_rem.n_got, n0 + 1)
    `CHK(i_rem.got, 8'h00)
    for (int c = 0; c < 4; c += 2)
    begin
      apb(1, IDX_BAUD, rate[c]);
      apb(1, IDX_TX_EXT, rate[c + 1]);
      apb(1, IDX_CTRL2, 8'h0D);
      apb(1, IDX_CTRL2, 8'h0C);
      for (k = 0; txd !== 1'b0 && k < 3000; k++) @(posedge clk);
      for (k = 0; txd === 1'b0 && k < 3000; k++) @(posedge clk);
      `CHK(k, 9 * period(rate[c], rate[c + 1]))
      repeat (600) @(posedge clk);
    end
    apb(1, IDX_BAUD, 8'h00);
    apb(1, IDX_TX_EXT, 8'h00);
    repeat (300) @(posedge clk);
    apb(1, IDX_INT_STAT, 8'h1F);
    apb(1, IDX_INT_MASK, 8'h00);
    seed = xs(seed);
    i_rem.send(seed[7:0]);
    repeat (40) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(0, IDX_INT_STAT, 8'h00);
    `CHK(rd[IRQ_RX_READY], 1'b1)
    apb(1, IDX_INT_MASK, 8'h04);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1, IDX_INT_STAT, 8'h04);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(0, IDX_STATUS, 8'h00);
    `CHK(rd[ST_RX_READY], 1'b1)
    apb(0, IDX_DATA, 8'h00);
    `CHK(rd[7:0], seed[7:0])
    apb(0, IDX_STATUS, 8'h00);
    `CHK(rd[ST_RX_READY], 1'b0)
    apb(1, IDX_CTRL1, 8'h08);
    apb(1, IDX_CTRL2, 8'h0E);
    i_rem.send(8'h12);
    repeat (40) @(posedge clk);
    apb(0, IDX_STATUS, 8'h00);
    `CHK(rd[ST_RX_READY], 1'b0)
    apb(0, IDX_CTRL2, 8'h00);
    `CHK(rd[7:0], 8'h0E)
    i_rem.send(8'h92);
    repeat (40) @(posedge clk);
    apb(0, IDX_CTRL2, 8'h00);
    `CHK(rd[7:0], 8'h0C)
    apb(0, IDX_STATUS, 8'h00);
    `CHK(rd[ST_RX_READY], 1'b1)
    apb(0, IDX_DATA, 8'h00);
    `CHK(rd[7:0], 8'h92)
    test_done;
  end
endmodule

// [verilog/serial_baud_gen.sv]
// one direction of the baud generator: prescaler, divisor, sixteen stage
`timescale 1ns/1ps
module serial_baud_gen (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic [1:0] pre_sel,
  input  wire logic [2:0] div_sel,
  input  wire logic [7:0] ext_div,
  output logic            os_tick,
  output logic            bit_tick
);
  import serial_pkg::*;

  logic [3:0] pre_cnt_q;
  logic [7:0] mid_cnt_q;
  logic [3:0] six_cnt_q;
  logic [7:0] mid_factor;
  logic       pre_tick;

  assign mid_factor = (ext_div != 8'h00) ? ext_div : 8'h01 << div_sel;
  assign pre_tick = (pre_cnt_q == 4'h0);

  // prescaler and divisor counters reload from the current setting at terminal count
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_cnt_q <= 4'h0;
      mid_cnt_q <= 8'h00;
      six_cnt_q <= 4'h0;
      os_tick   <= 1'b0;
      bit_tick  <= 1'b0;
    end
    else if (ce)
    begin
      pre_cnt_q <= pre_tick ? first_prescale_factor(pre_sel) - 4'h1
                            : pre_cnt_q - 4'h1;
      os_tick   <= 1'b0;
      bit_tick  <= 1'b0;
      if (pre_tick)
      begin
        if (mid_cnt_q == 8'h00)
        begin
          mid_cnt_q <= mid_factor - 8'h01;
          os_tick   <= 1'b1;
          six_cnt_q <= six_cnt_q + 4'h1;
          bit_tick  <= (six_cnt_q == OS_LAST);
        end
        else
          mid_cnt_q <= mid_cnt_q - 8'h01;
      end
    end
  end
endmodule

// [verilog/serial_pkg.sv]
// shared constants and types of the serial baud and control block
package serial_pkg;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS   = 10'h050;
  localparam logic [9:0] IDX_DATA     = 10'h051;
  localparam logic [9:0] IDX_BAUD     = 10'h052;
  localparam logic [9:0] IDX_CTRL1    = 10'h053;
  localparam logic [9:0] IDX_CTRL2    = 10'h054;
  localparam logic [9:0] IDX_RX_EXT   = 10'h055;
  localparam logic [9:0] IDX_TX_EXT   = 10'h057;
  localparam logic [9:0] IDX_INT_STAT = 10'h058;
  localparam logic [9:0] IDX_INT_MASK = 10'h059;

  // status fields
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_TX_DONE  = 6;
  localparam int ST_RX_READY = 5;
  localparam int ST_IDLE     = 4;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_NOISE    = 2;
  localparam int ST_FRAMING  = 1;
  // control one fields
  localparam int C1_RX_BIT8  = 7;
  localparam int C1_TX_BIT8  = 6;
  localparam int C1_WORD9    = 4;
  localparam int C1_WAKE     = 3;
  localparam logic [7:0] C1_WMASK = 8'h58;
  // control two fields
  localparam int C2_TX_EN    = 3;
  localparam int C2_RX_EN    = 2;
  localparam int C2_MUTE     = 1;
  localparam int C2_BREAK    = 0;
  // interrupt status and mask fields
  localparam int IRQ_TX_EMPTY = 0;
  localparam int IRQ_TX_DONE  = 1;
  localparam int IRQ_RX_READY = 2;
  localparam int IRQ_OVERRUN  = 3;
  localparam int IRQ_IDLE     = 4;
  localparam int IRQ_W        = 5;

  // reset values
  localparam logic [7:0] RST_STATUS = 8'hC0;
  localparam logic [7:0] RST_BYTE   = 8'h00;

  // timing counts
  localparam logic [3:0] OS_LAST    = 4'hF;
  localparam logic [3:0] SAMPLE_A   = 4'h7;
  localparam logic [3:0] SAMPLE_B   = 4'h8;
  localparam logic [3:0] SAMPLE_C   = 4'h9;
  localparam logic [3:0] BITS_WORD8 = 4'h9;
  localparam logic [3:0] BITS_WORD9 = 4'hA;
  localparam logic [7:0] IDLE_OS8   = 8'hA0;
  localparam logic [7:0] IDLE_OS9   = 8'hB0;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // coarse prescaler factor from its two-bit selector
  function automatic logic [3:0] first_prescale_factor(input logic [1:0] s);
    case (s)
      2'b00:   first_prescale_factor = 4'h1;
      2'b01:   first_prescale_factor = 4'h3;
      2'b10:   first_prescale_factor = 4'h4;
      default: first_prescale_factor = 4'hD;
    endcase
  endfunction

endpackage

// [verilog/serial_sync.sv]
// two-stage synchroniser for the serial receive pin
`timescale 1ns/1ps
module serial_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end
    else if (ce)
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// [verilog/serial_top.sv]
// asynchronous serial interface: registers, baud clocks, tx and rx engines
`timescale 1ns/1ps
module serial_top (
  input  wire logic                 CLK,
  input  wire logic                 RSTN,
  input  wire logic                 CE,
  input  wire serial_pkg::apb_req_t APB_REQ,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 RXD,
  output logic                      TXD,
  output logic                      IRQ
);
  import serial_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_START = 3'b010,
    RX_DATA  = 3'b100
  } rx_state_t;

  logic [7:0]         baud_rate_select_q;
  logic [7:0]         ctrl1_q;
  logic [7:0]         ctrl2_q;
  logic [7:0]         rx_ext_prescale_q;
  logic [7:0]         tx_ext_prescale_q;
  logic [7:0]         tx_buffer_q;
  logic [7:0]         rx_buffer_q;
  logic               rx_bit8_q;
  logic               tx_empty_q;
  logic               tx_done_q;
  logic               rx_ready_q;
  logic               idle_q;
  logic               overrun_q;
  logic               noise_q;
  logic               framing_q;
  logic               status_seen_q;
  logic [IRQ_W-1:0]   int_stat_q;
  logic [IRQ_W-1:0]   int_mask_q;
  tx_state_t          tx_state_q;
  logic [9:0]         tx_shift_q;
  logic [3:0]         tx_cnt_q;
  logic               break_pend_q;
  rx_state_t          rx_state_q;
  logic [3:0]         os_cnt_q;
  logic [3:0]         rx_idx_q;
  logic [2:0]         samp_q;
  logic               rx_noise_q;
  logic [9:0]         rx_shift_q;
  logic [7:0]         idle_cnt_q;
  logic               idle_armed_q;
  logic [31:0]        rdata;
  logic               mapped;
  logic               rxd_s;
  logic               tx_os;
  logic               tx_bit;
  logic               rx_os;
  logic               rx_bit;

  // apb decode: setup, a wait cycle to register the answer, then accept
  logic [9:0] idx;
  logic       prep;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       wr_data;
  logic       rd_data;
  logic       acc_status;
  assign idx        = APB_REQ.paddr[11:2];
  assign prep       = APB_REQ.psel & APB_REQ.penable & ~PREADY;
  assign acc        = APB_REQ.psel & APB_REQ.penable & PREADY;
  assign wr         = acc & APB_REQ.pwrite & mapped;
  assign rd         = acc & ~APB_REQ.pwrite & mapped;
  assign wr_data    = wr & (idx == IDX_DATA);
  assign rd_data    = rd & (idx == IDX_DATA);
  assign acc_status = acc & mapped & (idx == IDX_STATUS);

  logic word9;
  logic tx_en;
  logic rx_en;
  assign word9 = ctrl1_q[C1_WORD9];
  assign tx_en = ctrl2_q[C2_TX_EN];
  assign rx_en = ctrl2_q[C2_RX_EN];

  serial_sync u_rx_sync (
    .clk  (CLK),
    .rstn (RSTN),
    .ce   (CE),
    .din  (RXD),
    .dout (rxd_s)
  );

  serial_baud_gen u_tx_baud (
    .clk      (CLK),
    .rstn     (RSTN),
    .ce       (CE),
    .pre_sel  (baud_rate_select_q[7:6]),
    .div_sel  (baud_rate_select_q[5:3]),
    .ext_div  (tx_ext_prescale_q),
    .os_tick  (tx_os),
    .bit_tick (tx_bit)
  );

  serial_baud_gen u_rx_baud (
    .clk      (CLK),
    .rstn     (RSTN),
    .ce       (CE),
    .pre_sel  (baud_rate_select_q[7:6]),
    .div_sel  (baud_rate_select_q[2:0]),
    .ext_div  (rx_ext_prescale_q),
    .os_tick  (rx_os),
    .bit_tick (rx_bit)
  );

  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    case (idx)
      IDX_STATUS:   rdata[7:0] = {tx_empty_q, tx_done_q, rx_ready_q, idle_q,
                                  overrun_q, noise_q, framing_q, 1'b0};
      IDX_DATA:     rdata[7:0] = rx_buffer_q;
      IDX_BAUD:     rdata[7:0] = baud_rate_select_q;
      IDX_CTRL1:    rdata[7:0] = {rx_bit8_q, ctrl1_q[6:0]};
      IDX_CTRL2:    rdata[7:0] = ctrl2_q;
      IDX_RX_EXT:   rdata[7:0] = rx_ext_prescale_q;
      IDX_TX_EXT:   rdata[7:0] = tx_ext_prescale_q;
      IDX_INT_STAT: rdata[IRQ_W-1:0] = int_stat_q;
      IDX_INT_MASK: rdata[IRQ_W-1:0] = int_mask_q;
      default:      mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PREADY  <= prep;
      PSLVERR <= prep & ~mapped;
      if (prep)
        PRDATA <= APB_REQ.pwrite ? 32'h0000_0000 : rdata;
    end
  end

  // software-written configuration
  logic rx_wake;
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      baud_rate_select_q <= RST_BYTE;
      ctrl1_q            <= RST_BYTE;
      ctrl2_q            <= RST_BYTE;
      rx_ext_prescale_q  <= RST_BYTE;
      tx_ext_prescale_q  <= RST_BYTE;
      int_mask_q         <= '0;
    end
    else if (CE)
    begin
      // hardware wake clears mute unless software writes control two in the same cycle
      if (rx_wake)
        ctrl2_q[C2_MUTE] <= 1'b0;
      if (wr)
      begin
        case (idx)
          IDX_BAUD:     baud_rate_select_q <= APB_REQ.pwdata[7:0];
          IDX_CTRL1:    ctrl1_q <= APB_REQ.pwdata[7:0] & C1_WMASK;
          IDX_CTRL2:    ctrl2_q <= APB_REQ.pwdata[7:0];
          IDX_RX_EXT:   rx_ext_prescale_q <= APB_REQ.pwdata[7:0];
          IDX_TX_EXT:   tx_ext_prescale_q <= APB_REQ.pwdata[7:0];
          IDX_INT_MASK: int_mask_q <= APB_REQ.pwdata[IRQ_W-1:0];
          default:      ;
        endcase
      end
    end
  end

  // transmitter
  logic tx_start;
  logic tx_brk_go;
  logic tx_dat_go;
  logic tx_frame_end;
  logic brk_wr;
  // a write that sets send-break asks for one break frame
  assign brk_wr       = wr & (idx == IDX_CTRL2) & APB_REQ.pwdata[C2_BREAK];
  assign tx_start     = tx_bit & tx_en &
                        ((tx_state_q == TX_IDLE) || (tx_cnt_q == 4'h0));
  // break first, while set or once after a pulse
  assign tx_brk_go    = tx_start & (ctrl2_q[C2_BREAK] | break_pend_q);
  // data moves only once the empty flag is clear
  assign tx_dat_go    = tx_start & ~tx_brk_go & ~tx_empty_q;
  assign tx_frame_end = tx_bit & (tx_state_q == TX_SEND) &
                        (tx_cnt_q == 4'h0) & ~tx_brk_go & ~tx_dat_go;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tx_state_q   <= TX_IDLE;
      tx_shift_q   <= 10'h3FF;
      tx_cnt_q     <= 4'h0;
      TXD          <= 1'b1;
      break_pend_q <= 1'b0;
      tx_buffer_q  <= RST_BYTE;
    end
    else if (CE)
    begin
      // data register writes go to the transmit buffer
      if (wr_data)
        tx_buffer_q <= APB_REQ.pwdata[7:0];
      // remember a break request until one is sent
      if (brk_wr)
        break_pend_q <= 1'b1;
      else if (tx_brk_go)
        break_pend_q <= 1'b0;
      if (!tx_en)
      begin
        tx_state_q <= TX_IDLE;
        tx_cnt_q   <= 4'h0;
        TXD        <= 1'b1;
      end
      else if (tx_brk_go || tx_dat_go)
      begin
        tx_state_q <= TX_SEND;
        TXD        <= 1'b0;
        tx_cnt_q   <= word9 ? BITS_WORD9 : BITS_WORD8;
        // nine-bit frames carry the extra data bit
        tx_shift_q <= tx_brk_go ? {1'b1, ~word9, 8'h00}
                    : {1'b1, word9 ? ctrl1_q[C1_TX_BIT8] : 1'b1, tx_buffer_q};
      end
      else if (tx_bit && tx_state_q == TX_SEND)
      begin
        if (tx_cnt_q != 4'h0)
        begin
          TXD        <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[9:1]};
          tx_cnt_q   <= tx_cnt_q - 4'h1;
        end
        else
          tx_state_q <= TX_IDLE;
      end
    end
  end

  // receiver
  logic       maj;
  logic       samp_odd;
  logic       bit_end;
  logic       frame_done;
  logic       rx_addr;
  logic       rx_accept;
  logic       idle_hit;
  logic [3:0] rx_last;
  assign maj      = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) |
                    (samp_q[0] & samp_q[2]);
  assign samp_odd = ~(&samp_q) & (|samp_q);
  assign bit_end  = rx_os & (os_cnt_q == OS_LAST);
  assign rx_last  = word9 ? BITS_WORD9 - 4'h1 : BITS_WORD8 - 4'h1;
  assign frame_done = bit_end & (rx_state_q == RX_DATA) &
                      (rx_idx_q == rx_last);
  assign rx_addr  = word9 ? rx_shift_q[8] : rx_shift_q[7];
  // address mark wakes and that frame is kept
  assign rx_accept = frame_done &
                     (~ctrl2_q[C2_MUTE] | (ctrl1_q[C1_WAKE] & rx_addr));
  assign idle_hit = rx_os & rx_en & (rx_state_q == RX_IDLE) & rxd_s &
                    (idle_cnt_q == (word9 ? IDLE_OS9 : IDLE_OS8) - 8'h01);
  // wake on idle line or address mark
  assign rx_wake  = ctrl2_q[C2_MUTE] &
                    ((idle_hit & ~ctrl1_q[C1_WAKE]) |
                     (frame_done & ctrl1_q[C1_WAKE] & rx_addr));

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rx_state_q <= RX_IDLE;
      os_cnt_q   <= 4'h0;
      rx_idx_q   <= 4'h0;
      samp_q     <= 3'b111;
      rx_noise_q <= 1'b0;
      rx_shift_q <= 10'h000;
      idle_cnt_q <= 8'h00;
    end
    else if (CE)
    begin
      if (!rx_en)
      begin
        rx_state_q <= RX_IDLE;
        idle_cnt_q <= 8'h00;
      end
      else if (rx_os)
      begin
        os_cnt_q <= os_cnt_q + 4'h1;
        if (os_cnt_q == SAMPLE_A || os_cnt_q == SAMPLE_B ||
            os_cnt_q == SAMPLE_C)
          samp_q <= {samp_q[1:0], rxd_s};
        case (rx_state_q)
          RX_IDLE:
          begin
            if (!rxd_s)
            begin
              rx_state_q <= RX_START;
              os_cnt_q   <= 4'h1;
              rx_noise_q <= 1'b0;
              idle_cnt_q <= 8'h00;
            end
            else if (!idle_hit)
              idle_cnt_q <= idle_cnt_q + 8'h01;
            else
              idle_cnt_q <= 8'h00;
          end
          RX_START:
          begin
            if (os_cnt_q == OS_LAST)
            begin
              rx_state_q <= maj ? RX_IDLE : RX_DATA;
              rx_idx_q   <= 4'h0;
              rx_noise_q <= samp_odd;
            end
          end
          RX_DATA:
          begin
            if (os_cnt_q == OS_LAST)
            begin
              rx_shift_q[rx_idx_q] <= maj;
              rx_noise_q <= rx_noise_q | samp_odd;
              rx_idx_q   <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_last)
                rx_state_q <= RX_IDLE;
            end
          end
          default: rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // status flags; hardware set wins over the software sequence
  logic tx_empty_set;
  logic rx_ready_set;
  logic overrun_set;
  logic idle_set;
  logic stop_ok;
  assign stop_ok      = maj;
  assign tx_empty_set = tx_dat_go;
  assign rx_ready_set = rx_accept & ~rx_ready_q;
  assign overrun_set  = rx_accept & rx_ready_q;
  assign idle_set     = idle_hit & ~ctrl2_q[C2_MUTE] & idle_armed_q;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      {tx_empty_q, tx_done_q, rx_ready_q, idle_q, overrun_q, noise_q,
       framing_q} <= RST_STATUS[7:1];
      status_seen_q <= 1'b0;
      idle_armed_q  <= 1'b0;
      rx_buffer_q   <= RST_BYTE;
      rx_bit8_q     <= 1'b0;
    end
    else if (CE)
    begin
      if (acc_status)
        status_seen_q <= 1'b1;
      else if (wr_data || rd_data)
        status_seen_q <= 1'b0;
      if (wr_data && status_seen_q)
      begin
        tx_empty_q <= 1'b0;
        tx_done_q  <= 1'b0;
      end
      // status access then data read, or receiver off
      if (!rx_en || (rd_data && status_seen_q))
      begin
        rx_ready_q <= 1'b0;
        idle_q     <= 1'b0;
        overrun_q  <= 1'b0;
        noise_q    <= 1'b0;
        framing_q  <= 1'b0;
      end
      if (tx_empty_set)
        tx_empty_q <= 1'b1;
      if (tx_frame_end)
        tx_done_q <= 1'b1;
      if (rx_en && rx_ready_set)
      begin
        rx_buffer_q  <= rx_shift_q[7:0];
        rx_bit8_q    <= word9 & rx_shift_q[8];
        rx_ready_q   <= 1'b1;
        noise_q      <= rx_noise_q | samp_odd;
        framing_q    <= ~stop_ok;
        idle_armed_q <= 1'b1;
      end
      if (rx_en && overrun_set)
        overrun_q <= 1'b1;
      if (rx_en && idle_set)
      begin
        idle_q       <= 1'b1;
        idle_armed_q <= 1'b0;
      end
    end
  end

  // interrupt status, write one to clear, set wins
  logic [IRQ_W-1:0] int_ev;
  always_comb
  begin
    int_ev               = '0;
    int_ev[IRQ_TX_EMPTY] = tx_empty_set;
    int_ev[IRQ_TX_DONE]  = tx_frame_end;
    int_ev[IRQ_RX_READY] = rx_en & rx_ready_set;
    int_ev[IRQ_OVERRUN]  = rx_en & overrun_set;
    int_ev[IRQ_IDLE]     = rx_en & idle_set;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      int_stat_q <= '0;
      IRQ        <= 1'b0;
    end
    else if (CE)
    begin
      int_stat_q <= (int_stat_q &
                     ~((wr && idx == IDX_INT_STAT) ?
                       APB_REQ.pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}})) | int_ev;
      IRQ        <= |(int_stat_q & int_mask_q);
    end
  end
endmodule
